// ===== csa_seq.sv
`timescale 1ns/10ps
module csa_seq #(
    parameter int SETS   = csa_pkg::SET_MAX,
    parameter int SETTLE = csa_pkg::SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         arst_n,
    // Pins
    input  wire logic                         frame_trig,
    input  wire logic                         line1,
    input  wire logic                         line2,
    // Register port
    input  wire logic [csa_pkg::REG_ADDR_W-1:0] reg_addr,
    input  wire logic [csa_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [csa_pkg::DATA_W-1:0]   reg_rdata,
    // Sequencer state
    output logic      [csa_pkg::PAR_W-1:0]    active_params,
    output logic      [csa_pkg::IDX_W-1:0]    cur_index,
    output logic                              waiting_trig,
    output logic                              frame_start
);
    typedef struct packed {
        logic                          en;
        csa_pkg::csa_src_t             src;
        logic                          rst_en;
        logic                          rst_sel;
        logic                          inv1;
        logic                          inv2;
        logic [csa_pkg::CNT_W-1:0]     total;
        logic [csa_pkg::IDX_W-1:0]     wr_index;
        logic [csa_pkg::IDX_W-1:0]     idx;
        logic                          load_pend;
        logic [csa_pkg::PAR_W-1:0]     active;
        logic [csa_pkg::PAR_W-1:0]     saved;
        logic                          trig_d;
        logic                          l1_d;
        logic                          l2_d;
        logic [csa_pkg::SETTLE_W-1:0]  settle;
        logic                          fstart;
        logic [csa_pkg::DATA_W-1:0]    rdata;
    } csa_st_t;

    csa_st_t st;
    csa_st_t next_st;

    logic                        trig_s;
    logic                        l1_s;
    logic                        l2_s;
    logic                        mem_wr;
    logic [csa_pkg::PAR_W-1:0]   mem_rd;
    logic [csa_pkg::IDX_W-1:0]   next_idx_plus;
    logic                        trig_rise;
    logic                        lv1;
    logic                        lv2;
    logic                        step_sw;
    logic                        line_chg;
    logic                        trig_ok;

    csa_sync u_sync_trig (
        .mclk   (mclk),
        .arst_n (arst_n),
        .d      (frame_trig),
        .q      (trig_s)
    );

    csa_sync u_sync_l1 (
        .mclk   (mclk),
        .arst_n (arst_n),
        .d      (line1),
        .q      (l1_s)
    );

    csa_sync u_sync_l2 (
        .mclk   (mclk),
        .arst_n (arst_n),
        .d      (line2),
        .q      (l2_s)
    );

    assign mem_wr = reg_wr && (reg_addr == csa_pkg::REG_WR_DATA);

    csa_set_mem #(
        .DEPTH (SETS),
        .AW    (csa_pkg::IDX_W),
        .DW    (csa_pkg::PAR_W)
    ) u_mem (
        .mclk    (mclk),
        .wr_en   (mem_wr),
        .wr_addr (st.wr_index),
        .wr_data (reg_wdata),
        .rd_addr (next_st.idx),
        .rd_data (mem_rd)
    );

    // Line levels, inverted when inv1/inv2 are set, used by the source and restart decisions
    assign lv1 = l1_s ^ st.inv1;
    assign lv2 = l2_s ^ st.inv2;
    assign line_chg = (l1_s != st.l1_d) || (l2_s != st.l2_d);
    assign trig_rise = trig_s && !st.trig_d;
    assign step_sw = reg_wr && (reg_addr == csa_pkg::REG_STEP);
    assign trig_ok = trig_rise && (st.settle == '0) && !line_chg;

    // Wrap after the last configured index
    always_comb begin
        if ({1'b0, st.idx} + 7'h01 >= st.total) begin
            next_idx_plus = '0;
        end else begin
            next_idx_plus = st.idx + 6'h01;
        end
    end

    always_comb begin
        logic adv;
        logic rst_req;
        adv     = 1'b0;
        rst_req = 1'b0;
        next_st = st;
        next_st.trig_d    = trig_s;
        next_st.l1_d      = l1_s;
        next_st.l2_d      = l2_s;
        next_st.fstart    = 1'b0;
        next_st.load_pend = 1'b0;
        next_st.rdata     = '0;

        // Settle window after any line edge
        if (line_chg) begin
            next_st.settle = csa_pkg::SETTLE_W'(SETTLE);
        end else if (st.settle != '0) begin
            next_st.settle = st.settle - 9'h001;
        end

        if (st.en && trig_ok) begin
            next_st.fstart = 1'b1;
            case (st.src)
                csa_pkg::SRC_ALWAYS: adv = 1'b1;
                csa_pkg::SRC_LINE1:  adv = lv1;
                csa_pkg::SRC_LINE2:  adv = lv2;
                csa_pkg::SRC_OFF:    adv = 1'b0;
                default:             adv = 1'b0;
            endcase
            rst_req = st.rst_en && (st.rst_sel ? lv2 : lv1);
        end
        if (st.en && step_sw && st.src == csa_pkg::SRC_OFF) begin
            adv = 1'b1;
        end

        if (st.en) begin
            if (rst_req) begin
                next_st.idx       = '0;
                next_st.load_pend = 1'b1;
            end else if (adv) begin
                next_st.idx       = next_idx_plus;
                next_st.load_pend = 1'b1;
            end
        end
        if (st.load_pend) begin
            next_st.active = mem_rd;
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                csa_pkg::REG_CTRL: begin
                    if (reg_wdata[csa_pkg::CTRL_EN_BIT] && !st.en) begin
                        next_st.saved     = st.active;
                        next_st.idx       = '0;
                        next_st.load_pend = 1'b1;
                    end
                    if (!reg_wdata[csa_pkg::CTRL_EN_BIT] && st.en) begin
                        next_st.active    = st.saved;
                        next_st.load_pend = 1'b0;
                    end
                    next_st.en = reg_wdata[csa_pkg::CTRL_EN_BIT];
                    next_st.src = csa_pkg::csa_src_t'(
                        reg_wdata[csa_pkg::CTRL_SRC_LSB +: 2]);
                    next_st.rst_en  = reg_wdata[csa_pkg::CTRL_RST_EN_BIT];
                    next_st.rst_sel = reg_wdata[csa_pkg::CTRL_RST_SEL_BIT];
                    next_st.inv1    = reg_wdata[csa_pkg::CTRL_INV1_BIT];
                    next_st.inv2    = reg_wdata[csa_pkg::CTRL_INV2_BIT];
                end
                csa_pkg::REG_TOTAL: begin
                    if (!st.en) begin
                        if (reg_wdata[csa_pkg::CNT_W-1:0] == '0) begin
                            next_st.total = csa_pkg::TOTAL_RESET;
                        end else if (reg_wdata[csa_pkg::CNT_W-1:0]
                                     > csa_pkg::CNT_W'(SETS)) begin
                            next_st.total = csa_pkg::CNT_W'(SETS);
                        end else begin
                            next_st.total = reg_wdata[csa_pkg::CNT_W-1:0];
                        end
                    end
                end
                csa_pkg::REG_WR_INDEX: begin
                    next_st.wr_index = reg_wdata[csa_pkg::IDX_W-1:0];
                end
                csa_pkg::REG_ACTIVE: begin
                    if (!st.en) begin
                        next_st.active = reg_wdata;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads
        if (reg_rd) begin
            case (reg_addr)
                csa_pkg::REG_CTRL: begin
                    next_st.rdata[csa_pkg::CTRL_EN_BIT]       = st.en;
                    next_st.rdata[csa_pkg::CTRL_SRC_LSB +: 2] = st.src;
                    next_st.rdata[csa_pkg::CTRL_RST_EN_BIT]   = st.rst_en;
                    next_st.rdata[csa_pkg::CTRL_RST_SEL_BIT]  = st.rst_sel;
                    next_st.rdata[csa_pkg::CTRL_INV1_BIT]     = st.inv1;
                    next_st.rdata[csa_pkg::CTRL_INV2_BIT]     = st.inv2;
                end
                csa_pkg::REG_TOTAL: begin
                    next_st.rdata[csa_pkg::CNT_W-1:0] = st.total;
                end
                csa_pkg::REG_STATUS: begin
                    next_st.rdata[csa_pkg::IDX_W-1:0] = st.idx;
                    next_st.rdata[csa_pkg::IDX_W]     =
                        (st.settle == '0) && !line_chg;
                end
                csa_pkg::REG_WR_INDEX: begin
                    next_st.rdata[csa_pkg::IDX_W-1:0] = st.wr_index;
                end
                csa_pkg::REG_SAVED: next_st.rdata = st.saved;
                csa_pkg::REG_ACTIVE: next_st.rdata = st.active;
                default: next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st        <= '0;
            st.src    <= csa_pkg::SRC_ALWAYS;
            st.total  <= csa_pkg::TOTAL_RESET;
            st.active <= csa_pkg::ACTIVE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata     = st.rdata;
    assign active_params = st.active;
    assign cur_index     = st.idx;
    assign waiting_trig  = (st.settle == '0) && !line_chg;
    assign frame_start   = st.fstart;

    a_restart_zero: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.en && trig_ok && st.rst_en && (st.rst_sel ? lv2 : lv1) && !reg_wr
        |=> st.idx == '0)
        else $error("restart did not select set zero");
    a_always_step: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.en && trig_ok && st.src == csa_pkg::SRC_ALWAYS && !st.rst_en
        && !reg_wr |=> st.idx == $past(next_idx_plus))
        else $error("always source did not step");
    a_off_holds: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.en && st.src == csa_pkg::SRC_OFF && !st.rst_en && !reg_wr
        |=> st.idx == $past(st.idx))
        else $error("disabled source moved without command");
    a_line_low_hold: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.en && st.src == csa_pkg::SRC_LINE1 && !lv1 && !st.rst_en
        && !reg_wr |=> st.idx == $past(st.idx))
        else $error("line source stepped with line low");
    a_line_step: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.en && trig_ok && st.src == csa_pkg::SRC_LINE2 && lv2
        && !st.rst_en && !reg_wr |=> st.idx == $past(next_idx_plus))
        else $error("line source did not step with line high");
    a_idx_range: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.en |-> {1'b0, st.idx} < st.total)
        else $error("index outside configured count");
    a_wrap_zero: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.en && trig_ok && st.src == csa_pkg::SRC_ALWAYS && !st.rst_en
        && !reg_wr && {1'b0, st.idx} + 7'h01 == st.total |=> st.idx == '0)
        else $error("last set did not wrap to zero");
    a_ascend_only: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.en && $past(st.en) && st.idx != $past(st.idx)
        |-> st.idx == '0 || st.idx == $past(st.idx) + 6'h01)
        else $error("index moved out of ascending order");
    a_sw_step: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.en && step_sw && st.src == csa_pkg::SRC_OFF && !st.rst_en
        |=> st.idx == $past(next_idx_plus))
        else $error("software step command did not step");
    a_ignore_settle: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.settle != '0 |=> !st.fstart)
        else $error("trigger taken during line change");
    a_fstart_pulse: assert property (@(posedge mclk)
        disable iff (!arst_n)
        st.fstart |=> !st.fstart)
        else $error("frame start longer than one cycle");
    a_enable_zero: assert property (@(posedge mclk)
        disable iff (!arst_n)
        $rose(st.en) |-> st.idx == '0 ##1 st.active == mem_rd)
        else $error("enable did not load set zero");
    a_disable_back: assert property (@(posedge mclk)
        disable iff (!arst_n)
        $fell(st.en) |-> st.active == st.saved)
        else $error("disable did not restore values");
    a_idle_hold: assert property (@(posedge mclk)
        disable iff (!arst_n)
        !st.en && !reg_wr |=> st.idx == $past(st.idx))
        else $error("index moved while sequencer disabled");

    c_wrap: cover property (@(posedge mclk) disable iff (!arst_n)
        st.en && st.idx != '0 ##1 st.idx == '0);
    c_restart: cover property (@(posedge mclk) disable iff (!arst_n)
        st.en && trig_ok && st.rst_en);
    c_sw_step: cover property (@(posedge mclk) disable iff (!arst_n)
        st.en && step_sw && st.src == csa_pkg::SRC_OFF);
    c_line_step: cover property (@(posedge mclk) disable iff (!arst_n)
        st.en && trig_ok && st.src == csa_pkg::SRC_LINE1 && lv1);
    c_disable: cover property (@(posedge mclk) disable iff (!arst_n)
        $fell(st.en));
endmodule

// ===== csa_pkg.sv
// Package: constants and types of the controlled sequence advance block
package csa_pkg;
    localparam int SET_MAX        = 64;
    localparam int IDX_W          = 6;
    localparam int CNT_W          = 7;
    localparam int PAR_W          = 32;
    localparam int REG_ADDR_W     = 4;
    localparam int DATA_W         = 32;
    localparam int SYNC_STAGES    = 2;

    // Register offsets
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_TOTAL    = 4'h1;
    localparam logic [3:0] REG_STEP     = 4'h2;
    localparam logic [3:0] REG_STATUS   = 4'h3;
    localparam logic [3:0] REG_WR_INDEX = 4'h4;
    localparam logic [3:0] REG_WR_DATA  = 4'h5;
    localparam logic [3:0] REG_SAVED    = 4'h6;
    localparam logic [3:0] REG_ACTIVE   = 4'h7;

    // Control field positions
    localparam int CTRL_EN_BIT      = 0;
    localparam int CTRL_SRC_LSB     = 1;
    localparam int CTRL_RST_EN_BIT  = 3;
    localparam int CTRL_RST_SEL_BIT = 4;
    localparam int CTRL_INV1_BIT    = 5;
    localparam int CTRL_INV2_BIT    = 6;

    // Reset values
    localparam logic [CNT_W-1:0] TOTAL_RESET  = 7'h01;
    localparam logic [PAR_W-1:0] ACTIVE_RESET = 32'h0000_0000;

    // Line glitch window: trigger ignored while either input line settles, whether or not it controls the sequence
    localparam int CLK_MHZ      = 250;
    localparam int SETTLE_NS    = 1000;
    localparam int SETTLE_CYC   = (SETTLE_NS * CLK_MHZ) / 1000;
    localparam int SETTLE_W     = 9;

    typedef enum logic [1:0] {
        SRC_ALWAYS,
        SRC_LINE1,
        SRC_LINE2,
        SRC_OFF
    } csa_src_t;
endpackage

// ===== csa_sync.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module csa_sync (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic arst_n,
    // Level
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } csa_sync_st_t;

    csa_sync_st_t st;
    csa_sync_st_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule

// ===== csa_set_mem.sv
// Memory holding the stored parameter sets, registered read
`timescale 1ns/10ps
module csa_set_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6,
    parameter int DW    = 32
) (
    // Clock
    input  wire logic          mclk,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== csa_src_model.sv
// Trigger source and input line driver facing the sequencer pins
`timescale 1ns/10ps
module csa_src_model #(
    parameter int SETTLE = 8,
    parameter int HOLD   = 6
) (
    // Clock
    input  wire logic mclk,
    // Device status
    input  wire logic waiting_trig,
    // Pins
    output logic      frame_trig,
    output logic      line1,
    output logic      line2
);
    initial begin
        frame_trig = 1'b0;
        line1      = 1'b0;
        line2      = 1'b0;
    end

    // Set lines, let them settle, trigger once waiting is shown or after 200 more cycles
    task automatic frame(input logic l1, input logic l2, output logic ok);
        int n;
        n = 0;
        @(posedge mclk);
        line1 <= l1;
        line2 <= l2;
        repeat (SETTLE + 6) @(posedge mclk);
        while (waiting_trig !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        ok = (n < 200);
        frame_trig <= 1'b1;
        repeat (HOLD) @(posedge mclk);
        frame_trig <= 1'b0;
        repeat (HOLD) @(posedge mclk);
    endtask

    // Misbehaving source: triggers while line 1 is still settling
    task automatic rude(input logic l1, output logic seen_wait);
        @(posedge mclk);
        line1 <= l1;
        repeat (3) @(posedge mclk);
        seen_wait = waiting_trig;
        frame_trig <= 1'b1;
        repeat (HOLD) @(posedge mclk);
        frame_trig <= 1'b0;
        repeat (SETTLE + 6) @(posedge mclk);
    endtask
endmodule

// ===== controlled_sequence_advance_test.sv
// Self-checking bench for the controlled sequence advance block
`timescale 1ns/10ps
module controlled_sequence_advance_test;
    logic        mclk;
    logic        arst_n;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [31:0] active_params;
    logic [5:0]  cur_index;
    logic        waiting_trig;
    logic        frame_start;
    logic        frame_trig;
    logic        line1;
    logic        line2;
    logic [31:0] setv [64];
    logic [31:0] pre;
    logic [31:0] ctrl;
    logic [31:0] seed;
    logic [31:0] d;
    logic [5:0]  exp_idx;
    logic        w;
    int          tot;
    int          n_fs = 0;
    int          n_mismatch = 0;
    int          n_compared = 0;

    csa_seq #(.SETS(64), .SETTLE(8)) DUT (
        .mclk(mclk), .arst_n(arst_n), .frame_trig(frame_trig),
        .line1(line1), .line2(line2), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .active_params(active_params),
        .cur_index(cur_index), .waiting_trig(waiting_trig),
        .frame_start(frame_start));

    csa_src_model #(.SETTLE(8), .HOLD(6)) src (
        .mclk(mclk), .waiting_trig(waiting_trig),
        .frame_trig(frame_trig), .line1(line1), .line2(line2));

    always #2 mclk = ~mclk;

    always @(posedge mclk) if (frame_start === 1'b1) n_fs <= n_fs + 1;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] mk(input logic [1:0] s, input logic ren,
                                       input logic rsel, input logic inv);
        logic [31:0] c;
        c = 32'h0;
        c[csa_pkg::CTRL_SRC_LSB +: 2] = s;
        c[csa_pkg::CTRL_RST_EN_BIT]   = ren;
        c[csa_pkg::CTRL_RST_SEL_BIT]  = rsel;
        c[csa_pkg::CTRL_INV1_BIT]     = inv;
        c[csa_pkg::CTRL_INV2_BIT]     = inv;
        return c;
    endfunction

    function automatic logic [5:0] stepi(input logic [5:0] i);
        return (32'(i) == tot - 1) ? 6'h00 : i + 6'h01;
    endfunction

    function automatic logic [5:0] nxt(input logic [5:0] i, input logic l1,
                                       input logic l2);
        logic [1:0] s;
        logic       e1;
        logic       e2;
        s  = ctrl[csa_pkg::CTRL_SRC_LSB +: 2];
        e1 = l1 ^ ctrl[csa_pkg::CTRL_INV1_BIT];
        e2 = l2 ^ ctrl[csa_pkg::CTRL_INV2_BIT];
        if (ctrl[csa_pkg::CTRL_RST_EN_BIT] &&
            (ctrl[csa_pkg::CTRL_RST_SEL_BIT] ? e2 : e1)) return 6'h00;
        if (s == 2'(csa_pkg::SRC_ALWAYS) || (s == 2'(csa_pkg::SRC_LINE1) && e1)
            || (s == 2'(csa_pkg::SRC_LINE2) && e2)) return stepi(i);
        return i;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic cfg_on(input logic [31:0] c);
        ctrl = c | 32'h1;
        wr(csa_pkg::REG_CTRL, ctrl);
        repeat (2) @(posedge mclk);
        #1 exp_idx = 6'h00;
        check(32'(cur_index), 32'h0);
        check(active_params, setv[0]);
        rd(csa_pkg::REG_CTRL, d);
        check(d, ctrl);
    endtask

    task automatic cfg_off();
        ctrl = ctrl & ~32'h1;
        wr(csa_pkg::REG_CTRL, ctrl);
        repeat (2) @(posedge mclk);
        #1 check(active_params, pre);
        rd(csa_pkg::REG_SAVED, d);
        check(d, pre);
    endtask

    task automatic do_frames(input int n);
        logic [31:0] r;
        logic        ok;
        int          f0;
        for (int k = 0; k < n; k++) begin
            r  = rnd();
            f0 = n_fs;
            src.frame(r[0], r[1], ok);
            #1 exp_idx = nxt(exp_idx, r[0], r[1]);
            check(32'(ok), 32'h1);
            check(32'(n_fs - f0), 32'h1);
            check(32'(cur_index), 32'(exp_idx));
            check(active_params, setv[exp_idx]);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end

    initial begin
        seed      = 32'h7a5f;
        mclk      = 1'b0;
        arst_n    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        ctrl      = 32'h0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        #1 check(32'(cur_index), 32'h0);
        check(32'(waiting_trig), 32'h1);
        rd(csa_pkg::REG_TOTAL, d);
        check(d, 32'h1);
        wr(csa_pkg::REG_TOTAL, 32'h0);
        rd(csa_pkg::REG_TOTAL, d);
        check(d, 32'h1);
        wr(csa_pkg::REG_TOTAL, 32'h64);
        rd(csa_pkg::REG_TOTAL, d);
        check(d, 32'h40);
        rd(4'hf, d);
        check(d, 32'h0);
        tot = 64;
        pre = rnd();
        wr(csa_pkg::REG_ACTIVE, pre);
        for (int i = 0; i < 64; i++) begin
            setv[i] = rnd();
            wr(csa_pkg::REG_WR_INDEX, 32'(i));
            wr(csa_pkg::REG_WR_DATA, setv[i]);
        end
        $display("test setup done");
        cfg_on(mk(2'(csa_pkg::SRC_ALWAYS), 1'b0, 1'b0, 1'b0));
        wr(csa_pkg::REG_TOTAL, 32'h6);
        rd(csa_pkg::REG_TOTAL, d);
        check(d, 32'h40);
        do_frames(66);
        cfg_off();
        $display("test always active done");
        wr(csa_pkg::REG_TOTAL, 32'h6);
        tot = 6;
        for (int r = 0; r < 2; r++) begin
            cfg_on(mk(2'(csa_pkg::SRC_ALWAYS), 1'b1, r[0], 1'b0));
            do_frames(12);
            cfg_off();
        end
        $display("test restart done");
        for (int s = 1; s < 3; s++) begin
            for (int v = 0; v < 2; v++) begin
                cfg_on(mk(s[1:0], 1'b0, 1'b0, v[0]));
                do_frames(10);
                cfg_off();
            end
        end
        $display("test line source done");
        cfg_on(mk(2'(csa_pkg::SRC_OFF), 1'b0, 1'b0, 1'b0));
        do_frames(3);
        for (int k = 0; k < 7; k++) begin
            wr(csa_pkg::REG_STEP, 32'h0);
            repeat (2) @(posedge mclk);
            #1 exp_idx = stepi(exp_idx);
            check(32'(cur_index), 32'(exp_idx));
        end
        rd(csa_pkg::REG_STATUS, d);
        check(d, {25'h0, 1'b1, exp_idx});
        cfg_off();
        $display("test software step done");
        cfg_on(mk(2'(csa_pkg::SRC_LINE1), 1'b0, 1'b0, 1'b0));
        do_frames(1);
        d = 32'(n_fs);
        src.rude(~line1, w);
        #1 check(32'(w), 32'h0);
        check(32'(n_fs), d);
        check(32'(cur_index), 32'(exp_idx));
        do_frames(4);
        cfg_off();
        $display("test line settle done");
        conclude();
    end
endmodule
